// File: hw/gdpc_ctrl.sv
// gdpc_ctrl.sv: motor controller end of a three phase gate driver
// assumes: fault line is open drain with pull-up; inputs synchronous to clk
//
// Summary of operation
// - remove all commands within fault hold time
// - fault line low from us shuts down
// - hold each shutdown level at least 3.0 us
// - on fault drive every command low promptly
// - wait 2 seconds before restarting switching
// - insert at least 2 us dead time
`timescale 1ns/10ps
`include "gdpc_cfg.svh"

module gdpc_ctrl
  import gdpc_pkg::*;
#(
  parameter int PHASES      = `GDPC_PHASES,
  parameter int RESTART_CYC = `GDPC_RESTART_CYC,
  parameter int SHDN_CYC    = `GDPC_SHDN_HOLD_CYC,
  parameter int FLT_CYC     = `GDPC_FLT_CYC,
  parameter int DEAD_CYC    = `GDPC_DEAD_CYC
) (
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  wire logic      run_enable,
  input  wire logic      shutdown_req,
  input  wire gdpc_cmd_t want,
  input  wire logic      fault_line_in,
  output logic           fault_line_out,
  output logic           fault_line_oe,
  output gdpc_cmd_t      cmd,
  output logic           fault_seen,
  output logic           running
);
  // ----------------------------------------------------------------------
  // counter widths
  // ----------------------------------------------------------------------
  localparam int RW = $clog2(RESTART_CYC + 1);
  localparam int SW = $clog2(SHDN_CYC + 1);
  localparam int FW = $clog2(FLT_CYC + 1);

  // ----------------------------------------------------------------------
  // fault line sensing with glitch filter
  // ----------------------------------------------------------------------
  logic          line_f;
  logic          next_line_f;
  logic [FW-1:0] fcnt;
  logic [FW-1:0] next_fcnt;

  always_comb begin
    next_line_f = line_f;
    next_fcnt   = '0;
    if (fault_line_in != line_f) begin
      next_fcnt = fcnt + FW'(1);
      if (fcnt == FW'(FLT_CYC - 1)) begin
        next_line_f = fault_line_in;
        next_fcnt   = '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      line_f <= 1'b1;
      fcnt   <= '0;
    end else begin
      line_f <= next_line_f;
      fcnt   <= next_fcnt;
    end
  end

  // ----------------------------------------------------------------------
  // controller state machine
  // ----------------------------------------------------------------------
  gdpc_state_e   state;
  gdpc_state_e   next_state;
  logic [RW-1:0] rcnt;
  logic [RW-1:0] next_rcnt;
  logic [SW-1:0] scnt;
  logic [SW-1:0] next_scnt;
  logic          drive_low;
  logic          next_drive_low;
  logic          next_fault_seen;
  logic          kill;

  // ----------------------------------------------------------------------
  // command kill
  // ----------------------------------------------------------------------
  // line low from any party is one wired-AND level
  assign kill = (state != GDPC_RUN) || !line_f || !fault_line_in;

  always_comb begin
    next_state      = state;
    next_rcnt       = rcnt;
    next_scnt       = (scnt != '0) ? scnt - SW'(1) : scnt;
    next_drive_low  = drive_low;
    next_fault_seen = fault_seen;
    case (state)
      GDPC_IDLE: begin
        if (run_enable && line_f && !shutdown_req) begin
          next_state = GDPC_RUN;
        end
      end

      GDPC_RUN: begin
        if (!line_f && !drive_low) begin
          next_state      = GDPC_TRIP;
          next_fault_seen = 1'b1;
        end else if (shutdown_req && scnt == '0) begin
          next_state     = GDPC_SHDN;
          next_drive_low = 1'b1;
          next_scnt      = SW'(SHDN_CYC);
        end else if (!run_enable) begin
          next_state = GDPC_IDLE;
        end
      end

      GDPC_SHDN: begin
        if (!shutdown_req && scnt == '0) begin
          next_drive_low = 1'b0;
          next_scnt      = SW'(SHDN_CYC);
          next_state     = GDPC_WAIT;
          next_rcnt      = RW'(RESTART_CYC);
        end
      end

      GDPC_TRIP: begin
        // commands already off; wait for line to return high
        if (line_f) begin
          next_state = GDPC_WAIT;
          next_rcnt  = RW'(RESTART_CYC);
        end
      end

      GDPC_WAIT: begin
        if (!line_f) begin
          next_rcnt = RW'(RESTART_CYC);
        end else if (rcnt != '0) begin
          next_rcnt = rcnt - RW'(1);
        end else if (scnt == '0) begin
          next_state      = GDPC_IDLE;
          next_fault_seen = 1'b0;
        end
      end

      default: begin
        next_state = GDPC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state      <= GDPC_IDLE;
      rcnt       <= '0;
      scnt       <= '0;
      drive_low  <= 1'b0;
      fault_seen <= 1'b0;
    end else begin
      state      <= next_state;
      rcnt       <= next_rcnt;
      scnt       <= next_scnt;
      drive_low  <= next_drive_low;
      fault_seen <= next_fault_seen;
    end
  end

  // ----------------------------------------------------------------------
  // registered pin and status outputs
  // ----------------------------------------------------------------------
  logic          next_fault_line_out;
  logic          next_fault_line_oe;
  logic          next_running;

  always_comb begin
    next_fault_line_out = 1'b0;
    next_fault_line_oe  = next_drive_low;
    next_running        = (next_state == GDPC_RUN);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fault_line_out <= 1'b0;
      fault_line_oe  <= 1'b0;
      running        <= 1'b0;
    end else begin
      fault_line_out <= next_fault_line_out;
      fault_line_oe  <= next_fault_line_oe;
      running        <= next_running;
    end
  end

  // ----------------------------------------------------------------------
  // per phase command pairs with dead time
  // ----------------------------------------------------------------------
  for (genvar p = 0; p < PHASES; p++) begin : g_ph
    gdpc_deadtime #(
      .DEAD_CYC (DEAD_CYC)
    ) u_dt (
      .clk   (clk),
      .rst_n (rst_n),
      .kill  (kill),
      .want  (want[p]),
      .cmd   (cmd[p])
    );
  end
endmodule

// File: include/gdpc_cfg.svh
// gdpc_cfg.svh: timing constants of the gate driver controller
// assumes: included by the package and the controller modules
`ifndef GDPC_CFG_SVH
`define GDPC_CFG_SVH

// ----------------------------------------------------------------------
// clock
// ----------------------------------------------------------------------
`define GDPC_CLK_HZ          20000000
// ----------------------------------------------------------------------
// shutdown level hold, least 3.0 us, in ns
// ----------------------------------------------------------------------
`define GDPC_SHDN_HOLD_NS    3000
`define GDPC_SHDN_HOLD_CYC   ((`GDPC_SHDN_HOLD_NS * (`GDPC_CLK_HZ / 1000000) + 999) / 1000)
// ----------------------------------------------------------------------
// dead time, least 2 us, in ns
// ----------------------------------------------------------------------
`define GDPC_DEAD_NS         2000
`define GDPC_DEAD_CYC        ((`GDPC_DEAD_NS * (`GDPC_CLK_HZ / 1000000) + 999) / 1000)
// ----------------------------------------------------------------------
// restart wait, least 2 s, in ms
// ----------------------------------------------------------------------
`define GDPC_RESTART_MS      2000
`define GDPC_RESTART_CYC     (`GDPC_RESTART_MS * (`GDPC_CLK_HZ / 1000))
// ----------------------------------------------------------------------
// fault line filter on the controller side, 2.5 us in ns
// ----------------------------------------------------------------------
`define GDPC_FLT_NS          2500
`define GDPC_FLT_CYC         ((`GDPC_FLT_NS * (`GDPC_CLK_HZ / 1000000) + 999) / 1000)
// ----------------------------------------------------------------------
// phase count
// ----------------------------------------------------------------------
`define GDPC_PHASES          3

`endif

// File: include/gdpc_pkg.sv
// gdpc_pkg.sv: types of the gate driver controller
// assumes: gdpc_cfg.svh on the include path
`include "gdpc_cfg.svh"
package gdpc_pkg;
  // ----------------------------------------------------------------------
  // controller states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    GDPC_IDLE  = 3'b000,
    GDPC_RUN   = 3'b001,
    GDPC_TRIP  = 3'b010,
    GDPC_SHDN  = 3'b011,
    GDPC_WAIT  = 3'b100
  } gdpc_state_e;
  // ----------------------------------------------------------------------
  // per phase command pair
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic high_side_cmd;
    logic low_side_cmd;
  } gdpc_phase_s;
  typedef gdpc_phase_s [`GDPC_PHASES-1:0] gdpc_cmd_t;
endpackage

// File: hw/gdpc_deadtime.sv
// gdpc_deadtime.sv: one phase dead time inserter
// assumes: wanted levels synchronous to clk; kill forces both sides off
`timescale 1ns/10ps
`include "gdpc_cfg.svh"

module gdpc_deadtime
  import gdpc_pkg::*;
#(
  parameter int DEAD_CYC = `GDPC_DEAD_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        kill,
  input  wire gdpc_phase_s want,
  output gdpc_phase_s      cmd
);
  localparam int CW = $clog2(DEAD_CYC + 1);
  gdpc_phase_s   next_cmd;
  logic [CW-1:0] gap;
  logic [CW-1:0] next_gap;

  // ----------------------------------------------------------------------
  // both sides off for DEAD_CYC before either turns on
  // ----------------------------------------------------------------------
  always_comb begin
    next_cmd = cmd;
    next_gap = gap;
    if (kill || (want.high_side_cmd && want.low_side_cmd)) begin
      next_cmd = '0;
      next_gap = CW'(DEAD_CYC);
    end else if (cmd.high_side_cmd && !want.high_side_cmd) begin
      next_cmd.high_side_cmd = 1'b0;
      next_gap = CW'(DEAD_CYC);
    end else if (cmd.low_side_cmd && !want.low_side_cmd) begin
      next_cmd.low_side_cmd = 1'b0;
      next_gap = CW'(DEAD_CYC);
    end else if (gap != '0) begin
      next_gap = gap - CW'(1);
    end else begin
      next_cmd = want;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd <= '0;
      gap <= CW'(DEAD_CYC);
    end else begin
      cmd <= next_cmd;
      gap <= next_gap;
    end
  end
endmodule

// File: bench/gdpc_ctrl_props.sv
// gdpc_ctrl_props.sv: port checks of the gate driver controller
// assumes: bound to gdpc_ctrl, fault line sensed through a pull-up
`timescale 1ns/10ps
module gdpc_ctrl_props
  import gdpc_pkg::*;
#(
  parameter int RESTART_CYC = 200,
  parameter int SHDN_CYC    = 60
) (
  input wire logic      clk,
  input wire logic      rst_n,
  input wire logic      running,
  input wire logic      shutdown_req,
  input wire logic      fault_line_in,
  input wire logic      fault_line_out,
  input wire logic      fault_line_oe,
  input wire gdpc_cmd_t cmd,
  input wire logic      fault_seen
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------------
  // cycle counters
  // ----------------------------------------------------------------------
  logic [31:0] lo_cnt;
  logic [31:0] hi_cnt;
  logic [31:0] seen_cnt;
  always_ff @(posedge clk) begin
    if (!rst_n || !fault_line_oe)
      lo_cnt <= 32'h00000000;
    else
      lo_cnt <= lo_cnt + 32'h00000001;
    if (!rst_n || !fault_seen)
      seen_cnt <= 32'h00000000;
    else
      seen_cnt <= seen_cnt + 32'h00000001;
    if (!rst_n)
      hi_cnt <= 32'hFFFFFFFF;
    else if (fault_line_oe)
      hi_cnt <= 32'h00000000;
    else if (hi_cnt != 32'hFFFFFFFF)
      hi_cnt <= hi_cnt + 32'h00000001;
  end
  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  sequence s_line_low;
    !fault_line_in [*2];
  endsequence
  property p_kill;    s_line_low |=> cmd == '0; endproperty
  property p_excl;    (cmd & (cmd >> 1) & 6'h15) == 6'h00; endproperty
  property p_cause;
    $rose(fault_line_oe) |-> $past(shutdown_req) && $past(running);
  endproperty
  property p_low_hold;  $fell(fault_line_oe) |-> lo_cnt >= SHDN_CYC; endproperty
  property p_high_hold; $rose(fault_line_oe) |-> hi_cnt >= SHDN_CYC; endproperty
  property p_trip_off;  fault_seen |-> !running && cmd == '0; endproperty
  property p_wait; $fell(fault_seen) |-> seen_cnt >= RESTART_CYC; endproperty
  property p_out;     !fault_line_out; endproperty
  a_kill:      assert property (p_kill)
    else $error("cmd live on low line");
  a_excl:      assert property (p_excl)
    else $error("both sides on");
  a_cause:     assert property (p_cause)
    else $error("pull without request");
  a_low_hold:  assert property (p_low_hold)
    else $error("low level short");
  a_high_hold: assert property (p_high_hold)
    else $error("high level short");
  a_trip_off:  assert property (p_trip_off)
    else $error("switching in fault");
  a_wait:      assert property (p_wait)
    else $error("restart too early");
  a_out:       assert property (p_out)
    else $error("line driven high");
endmodule

// File: bench/gdpc_drv_model.sv
// gdpc_drv_model.sv: behavioural gate driver with protection logic
// assumes: clk times the filters; fault line resolved by the bench
`timescale 1ns/10ps
module gdpc_drv_model
  import gdpc_pkg::*;
#(
  parameter int HOLD_CYC = 100,
  parameter int OC_F     = 6,
  parameter int UV_F     = 36,
  parameter int FL_F     = 50
) (
  input  wire logic       clk,
  input  wire gdpc_cmd_t  cmd,
  input  wire logic       fault_line,
  input  wire logic       oc_sense,
  input  wire logic       logic_ok,
  input  wire logic [2:0] boot_ok,
  output gdpc_cmd_t       gate,
  output logic            pull
);
  int         oc_cnt  = 0;
  int         uv_cnt  = 0;
  int         fl_cnt  = 0;
  int         hold    = 0;
  logic       line_f  = 1'b1;
  logic       uv_lock = 1'b0;
  logic [2:0] arm     = 3'b111;
  gdpc_cmd_t  cmd_q   = '0;
  always @(posedge clk) begin
    oc_cnt <= oc_sense ? oc_cnt + 1 : 0;
    if (oc_sense && oc_cnt == OC_F - 1)
      hold <= HOLD_CYC;
    else if (hold > 0)
      hold <= hold - 1;
    uv_cnt  <= logic_ok ? 0 : uv_cnt + 1;
    uv_lock <= !logic_ok && (uv_lock || uv_cnt >= UV_F - 1);
    fl_cnt  <= (fault_line == line_f) ? 0 : fl_cnt + 1;
    if (fault_line != line_f && fl_cnt == FL_F - 1)
      line_f <= fault_line;
    cmd_q <= cmd;
    for (int p = 0; p < 3; p++) begin
      if (!boot_ok[p])
        arm[p] <= 1'b0;
      else if (cmd[p].high_side_cmd && !cmd_q[p].high_side_cmd)
        arm[p] <= 1'b1;
    end
  end
  assign pull = uv_lock || hold > 0;
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      gate[p].high_side_cmd = cmd[p].high_side_cmd && arm[p]
                              && boot_ok[p];
      gate[p].low_side_cmd  = cmd[p].low_side_cmd && line_f
                              && !pull;
    end
  end
endmodule

// File: bench/tb.sv
// tb.sv: self-checking bench of the gate driver controller
// assumes: driver model on the far side, pull-up on the fault line
`timescale 1ns/10ps
module tb;
  import gdpc_pkg::*;
  localparam int RST = 200;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       run_enable = 1'b0;
  logic       shutdown_req = 1'b0;
  logic       oc = 1'b0;
  logic       lok = 1'b1;
  logic [2:0] bok = 3'b111;
  gdpc_cmd_t  want = '0;
  gdpc_cmd_t  cmd;
  gdpc_cmd_t  gate;
  logic       oe, out, seen, running, pull, line;
  int         error_cnt = 0;
  int         total_checks = 0;
  assign line = ~((oe & ~out) | pull);
  gdpc_ctrl #(.RESTART_CYC(RST)) u_gdpc_ctrl (.clk(clk), .rst_n(rst_n),
    .run_enable(run_enable), .shutdown_req(shutdown_req), .want(want),
    .fault_line_in(line), .fault_line_out(out), .fault_line_oe(oe),
    .cmd(cmd), .fault_seen(seen), .running(running));
  gdpc_drv_model u_gdpc_drv_model (.clk(clk), .cmd(cmd), .fault_line(line),
    .oc_sense(oc), .logic_ok(lok), .boot_ok(bok), .gate(gate), .pull(pull));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [5:0] e, input logic [5:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_run();
    for (int i = 0; i < 1000 && running !== 1'b1; i++) step(1);
    chk("running", 6'h01, {5'h00, running});
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic t_dead();
    run_enable = 1'b1;
    wait_run();
    want = 6'h02;
    step(45);
    chk("cmd", 6'h02, cmd);
    want = 6'h01;
    step(30);
    chk("cmd", 6'h00, cmd);
    step(20);
    chk("gate", 6'h01, gate);
    want = 6'h03;
    step(2);
    chk("cmd", 6'h00, cmd);
  endtask
  task automatic t_boot();
    bok = 3'b110;
    want = 6'h02;
    step(50);
    chk("gate", 6'h00, gate);
    chk("line", 6'h01, {5'h00, line});
    bok = 3'b111;
    step(5);
    chk("gate", 6'h00, gate);
    want = 6'h00;
    step(45);
    want = 6'h02;
    step(45);
    chk("gate", 6'h02, gate);
  endtask
  task automatic t_oc();
    int n;
    want = 6'h01;
    step(45);
    oc = 1'b1;
    step(10);
    oc = 1'b0;
    chk("line", 6'h00, {5'h00, line});
    chk("cmd", 6'h00, cmd);
    want = 6'h00;
    step(60);
    chk("seen", 6'h01, {5'h00, seen});
    chk("line", 6'h00, {5'h00, line});
    for (n = 0; n < 2000 && seen !== 1'b0; n++) step(1);
    chk("wait", 6'h01, {5'h00, n >= RST});
    wait_run();
  endtask
  task automatic t_shdn();
    shutdown_req = 1'b1;
    step(2);
    chk("oe", 6'h01, {5'h00, oe});
    chk("cmd", 6'h00, cmd);
    shutdown_req = 1'b0;
    step(30);
    chk("oe", 6'h01, {5'h00, oe});
    step(40);
    chk("oe", 6'h00, {5'h00, oe});
    chk("seen", 6'h00, {5'h00, seen});
    wait_run();
    lok = 1'b0;
    step(40);
    chk("line", 6'h00, {5'h00, line});
    step(60);
    chk("seen", 6'h01, {5'h00, seen});
    lok = 1'b1;
    step(1);
    chk("pull", 6'h00, {5'h00, pull});
    wait_run();
    run_enable = 1'b0;
    want = 6'h01;
    step(3);
    chk("running", 6'h00, {5'h00, running});
    chk("cmd", 6'h00, cmd);
  endtask
  initial begin
    step(10);
    rst_n = 1'b1;
    chk("cmd", 6'h00, cmd);
    chk("oe", 6'h00, {5'h00, oe});
    t_dead();
    t_boot();
    t_oc();
    t_shdn();
    final_report();
  end
  initial begin
    #(50 * 5000);
    error_cnt++;
    final_report();
  end
endmodule
bind gdpc_ctrl gdpc_ctrl_props #(.RESTART_CYC(RESTART_CYC),
  .SHDN_CYC(SHDN_CYC)) u_gdpc_ctrl_props (.clk(clk), .rst_n(rst_n),
  .running(running), .shutdown_req(shutdown_req),
  .fault_line_in(fault_line_in), .fault_line_out(fault_line_out),
  .fault_line_oe(fault_line_oe), .cmd(cmd), .fault_seen(fault_seen));
